//--- inc/prs_pkg.sv
// constants and types of the partition read-state and progress-flag logic
// assumes: one clock, command decoding and program/erase engine outside
`default_nettype none

package prs_pkg;

	// ----------------------------------------------------------------
	// partitions
	// ----------------------------------------------------------------
	localparam int         NUM_PART   = 8;
	localparam int         PART_W     = 3;
	localparam logic [2:0] PARAM_PART = 3'h0;

	// ----------------------------------------------------------------
	// progress flag byte: reset value and bit positions
	// ----------------------------------------------------------------
	localparam logic [7:0] FLAGS_RST      = 8'h80;
	localparam logic [7:0] STAT_HIGH_BYTE = 8'h00;
	localparam int         FLG_IDLE       = 7;
	localparam int         FLG_ERASE_HOLD = 6;
	localparam int         FLG_ERASE_FAIL = 5;
	localparam int         FLG_PROG_FAIL  = 4;
	localparam int         FLG_SUPPLY_LOW = 3;
	localparam int         FLG_PROG_HOLD  = 2;
	localparam int         FLG_LOCKED     = 1;
	localparam int         FLG_OWNER      = 0;

	// ----------------------------------------------------------------
	// pin vector layout after the synchroniser
	// ----------------------------------------------------------------
	localparam int PINS_W   = 7;
	localparam int PIN_CE   = 0;
	localparam int PIN_OE   = 1;
	localparam int PIN_ADV  = 2;
	localparam int PIN_BCLK = 3;
	localparam int PIN_PART = 4;

	// ----------------------------------------------------------------
	// burst length codes and beat counts
	// ----------------------------------------------------------------
	localparam logic [2:0] BL_4     = 3'h1;
	localparam logic [2:0] BL_8     = 3'h2;
	localparam logic [2:0] BL_16    = 3'h3;
	localparam logic [4:0] BEATS_4  = 5'h04;
	localparam logic [4:0] BEATS_8  = 5'h08;
	localparam logic [4:0] BEATS_16 = 5'h10;
	localparam logic [4:0] BEATS_CONT = 5'h00;

	typedef enum logic [1:0] {
		RS_ARRAY,
		RS_STATUS,
		RS_IDENT,
		RS_QUERY
	} prs_rstate_t;

	typedef enum logic [3:0] {
		CMD_READ_ARRAY,
		CMD_READ_STATUS,
		CMD_READ_IDENT,
		CMD_READ_QUERY,
		CMD_PROGRAM,
		CMD_ERASE,
		CMD_LOCK,
		CMD_PROT_PROGRAM,
		CMD_CLEAR_STATUS,
		CMD_OTHER
	} prs_cmd_t;

endpackage

`default_nettype wire

//--- inc/prs_flags_if.sv
// carrier between the read-state logic and the progress-flag keeper
// assumes: all signals on the one block clock
`default_nettype none

interface prs_flags_if;
	logic       eng_busy;
	logic       eng_erase_hold;
	logic       eng_prog_hold;
	logic       set_erase_fail;
	logic       set_prog_fail;
	logic       set_supply_low;
	logic       set_locked;
	logic       seq_err;
	logic       clear_req;
	logic [7:0] flags;

	modport keeper (
		input  eng_busy, eng_erase_hold, eng_prog_hold, set_erase_fail,
		       set_prog_fail, set_supply_low, set_locked, seq_err,
		       clear_req,
		output flags
	);
	modport user (
		output eng_busy, eng_erase_hold, eng_prog_hold, set_erase_fail,
		       set_prog_fail, set_supply_low, set_locked, seq_err,
		       clear_req,
		input  flags
	);
endinterface

`default_nettype wire

//--- logic/prs_flags.sv
// progress flag keeper: engine-owned bits and sticky error bits
// assumes: engine levels and set pulses on clk; owner bit filled by user
`default_nettype none

module prs_flags (
	input  wire logic       clk,  // block clock
	input  wire logic       rst_n, // async reset, active low
	prs_flags_if.keeper     fl    // engine side and flag byte
);

	typedef struct packed {
		logic [7:0] flags;
	} prs_flags_st_t;

	prs_flags_st_t q_r;
	prs_flags_st_t q_nxt;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		q_nxt = q_r;
		// engine sets and clears these freely
		q_nxt.flags[prs_pkg::FLG_IDLE]       = ~fl.eng_busy;
		q_nxt.flags[prs_pkg::FLG_ERASE_HOLD] = fl.eng_erase_hold;
		q_nxt.flags[prs_pkg::FLG_PROG_HOLD]  = fl.eng_prog_hold;
		// owner bit depends on the reader, filled in at snapshot
		q_nxt.flags[prs_pkg::FLG_OWNER]      = 1'b0;
		// sticky bits: clear first so a same-cycle set wins
		if (fl.clear_req) begin
			q_nxt.flags[prs_pkg::FLG_ERASE_FAIL] = 1'b0;
			q_nxt.flags[prs_pkg::FLG_PROG_FAIL]  = 1'b0;
			q_nxt.flags[prs_pkg::FLG_SUPPLY_LOW] = 1'b0;
			q_nxt.flags[prs_pkg::FLG_LOCKED]     = 1'b0;
		end
		if (fl.set_erase_fail || fl.seq_err) begin
			q_nxt.flags[prs_pkg::FLG_ERASE_FAIL] = 1'b1;
		end
		if (fl.set_prog_fail || fl.seq_err) begin
			q_nxt.flags[prs_pkg::FLG_PROG_FAIL] = 1'b1;
		end
		if (fl.set_supply_low) begin
			q_nxt.flags[prs_pkg::FLG_SUPPLY_LOW] = 1'b1;
		end
		if (fl.set_locked) begin
			q_nxt.flags[prs_pkg::FLG_LOCKED] = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q_r.flags <= prs_pkg::FLAGS_RST;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign fl.flags = q_r.flags;

endmodule

`default_nettype wire

//--- logic/prs_read_state.sv
// per-partition read state, read data steering and progress flag reads
// assumes: flash pins arrive unsynchronised; command decoder, engine,
// array and identifier/query data come from logic on clk
//
// What this block does
// - main partition busy: other partitions still serve query/protection reads
// - main partition busy: parameter partition still serves array reads
// - query/protection data served via partition neither busy nor param
// - protection program keeps parameter partition in status read state
// - param partition busy: query/protection reads still served but raise access_violation, array reads served
// - non-array reads are single words; later page words undefined
// - synchronous burst repeats non-array word until burst length delivered
// - every partition keeps its own independent read state
// - read-status command to a partition returns flags at its addresses
// - program, erase, lock switch that partition to status reads
// - status read drives flags on low byte, zero on high byte
// - async mode: flags captured on first falling of output/chip enable
// - status reads leave other partitions' read states untouched
// - idle flag: zero busy with owner bit valid, one ready
// - owner bit tells addressed partition versus another partition busy
// - erase hold flag is one exactly while erase is suspended
// - flag byte resets to idle bit only
// - idle and owner bits together encode the operation state
// - engine sets/clears bits 7,6,2,0; bits 5,4,3,1 sticky till clear
// - command sequence error sets bits 5 and 4 together
`default_nettype none

module prs_read_state (
	input  wire logic                  clk,             // block clock
	input  wire logic                  rst_n,           // async reset
	input  wire logic                  chip_en_n,       // chip enable pin
	input  wire logic                  out_en_n,        // output enable pin
	input  wire logic                  address_latch_n, // address latch pin
	input  wire logic                  burst_clk,       // burst clock pin
	input  wire logic [2:0]            part_addr,       // partition address
	input  wire logic                  sync_mode,       // 1 = sync burst
	input  wire logic [2:0]            burst_len,       // burst length code
	input  wire logic                  cmd_valid,       // command pulse
	input  wire prs_pkg::prs_cmd_t     cmd_kind,        // decoded command
	input  wire logic [2:0]            cmd_part,        // command partition
	input  wire logic                  eng_busy,        // engine running
	input  wire logic [2:0]            eng_part,        // engine partition
	input  wire logic                  eng_prot_prog,   // protection program
	input  wire logic                  eng_erase_hold,  // erase suspended
	input  wire logic                  eng_prog_hold,   // program suspended
	input  wire logic                  set_erase_fail,  // erase failed
	input  wire logic                  set_prog_fail,   // program failed
	input  wire logic                  set_supply_low,  // supply low
	input  wire logic                  set_locked,      // block locked
	input  wire logic                  seq_err,         // sequence error
	input  wire logic [15:0]           array_data,      // array read word
	input  wire logic [15:0]           nonarray_data,   // id/query word
	output logic      [15:0]           dq_out,          // data pins out
	output logic                       dq_oe,           // data pin enable
	output logic                       burst_done,      // burst delivered
	output logic                       access_violation, // forbidden access
	output logic      [15:0]           read_states      // 2 bits/partition
);

	// ----------------------------------------------------------------
	// state: synchroniser, read states and the latched access
	// ----------------------------------------------------------------
	// every flop of this module lives in this one struct
	typedef struct packed {
		logic [prs_pkg::PINS_W-1:0]                  s1;
		logic [prs_pkg::PINS_W-1:0]                  s2;
		logic [prs_pkg::PINS_W-1:0]                  prev;
		prs_pkg::prs_rstate_t [prs_pkg::NUM_PART-1:0] rstate;
		logic [7:0]                                  snap;
		logic [2:0]                                  lat_part;
		logic [15:0]                                 word;
		logic [4:0]                                  beats;
		logic [15:0]                                 dq_out;
		logic                                        dq_oe;
		logic                                        burst_done;
		logic                                        violation;
	} prs_rs_st_t;

	prs_rs_st_t q_r;
	prs_rs_st_t q_nxt;
	prs_flags_if fl ();

	// ----------------------------------------------------------------
	// flag keeper
	// ----------------------------------------------------------------
	prs_flags u_flags (
		.clk   (clk),
		.rst_n (rst_n),
		.fl    (fl.keeper)
	);

	// ----------------------------------------------------------------
	// engine hookup
	// ----------------------------------------------------------------
	// levels and pulses pass straight on; the keeper registers them
	assign fl.eng_busy       = eng_busy;
	assign fl.eng_erase_hold = eng_erase_hold;
	assign fl.eng_prog_hold  = eng_prog_hold;
	assign fl.set_erase_fail = set_erase_fail;
	assign fl.set_prog_fail  = set_prog_fail;
	assign fl.set_supply_low = set_supply_low;
	assign fl.set_locked     = set_locked;
	assign fl.seq_err        = seq_err;
	// clear leaves every read state alone
	assign fl.clear_req      = cmd_valid &&
	                           (cmd_kind == prs_pkg::CMD_CLEAR_STATUS);

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	function automatic logic [4:0] beats_of(input logic [2:0] code);
		unique case (code)
			prs_pkg::BL_4:  beats_of = prs_pkg::BEATS_4;
			prs_pkg::BL_8:  beats_of = prs_pkg::BEATS_8;
			prs_pkg::BL_16: beats_of = prs_pkg::BEATS_16;
			default:        beats_of = prs_pkg::BEATS_CONT;
		endcase
	endfunction

	function automatic logic is_nonarray(input prs_pkg::prs_rstate_t s);
		is_nonarray = (s == prs_pkg::RS_IDENT) || (s == prs_pkg::RS_QUERY);
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic                 ce_n;
		logic                 oe_n;
		logic                 adv_n;
		logic                 bclk_rise;
		logic                 start;
		logic [2:0]           part;
		prs_pkg::prs_rstate_t s_new;
		prs_pkg::prs_rstate_t s_cur;
		logic                 param_busy;
		logic                 main_busy;
		logic [4:0]           lim;
		logic [4:0]           cnt;
		logic                 bad_param;
		logic                 bad_prot;
		logic                 bad_main;

		start      = 1'b0;
		q_nxt      = q_r;
		ce_n       = q_r.s2[prs_pkg::PIN_CE];
		oe_n       = q_r.s2[prs_pkg::PIN_OE];
		adv_n      = q_r.s2[prs_pkg::PIN_ADV];
		bclk_rise  = q_r.s2[prs_pkg::PIN_BCLK] &&
		             !q_r.prev[prs_pkg::PIN_BCLK];
		part       = q_r.s2[prs_pkg::PIN_PART +: prs_pkg::PART_W];
		s_new      = q_r.rstate[part];
		s_cur      = q_r.rstate[q_r.lat_part];
		param_busy = eng_busy && !eng_prot_prog &&
		             (eng_part == prs_pkg::PARAM_PART);
		main_busy  = eng_busy && !eng_prot_prog &&
		             (eng_part != prs_pkg::PARAM_PART);
		lim        = beats_of(burst_len);
		cnt        = q_r.beats + 5'h01;
		// forbidden mixes are still served; they only raise the flag,
		// since refusing them would hide the host fault from the model
		bad_param  = param_busy && is_nonarray(s_new);
		bad_prot   = eng_prot_prog &&
		             (part == prs_pkg::PARAM_PART);
		bad_main   = main_busy && is_nonarray(s_new) &&
		             (part == prs_pkg::PARAM_PART);

		// ------------------------------------------------------------
		// pin synchroniser
		// ------------------------------------------------------------
		// pins pass two flops before use; prev is a third stage that
		// only feeds the edge detectors
		q_nxt.s1   = {part_addr, burst_clk, address_latch_n, out_en_n,
		              chip_en_n};
		q_nxt.s2   = q_r.s1;
		q_nxt.prev = q_r.s2;

		// ------------------------------------------------------------
		// read state per partition
		// ------------------------------------------------------------
		// only the commanded partition changes state, apart from the parameter
		// partition pinned below during protection programming; a status read
		// never moves any other partition
		if (cmd_valid) begin
			unique case (cmd_kind)
				prs_pkg::CMD_READ_ARRAY:
					q_nxt.rstate[cmd_part] = prs_pkg::RS_ARRAY;
				prs_pkg::CMD_READ_STATUS:
					q_nxt.rstate[cmd_part] = prs_pkg::RS_STATUS;
				prs_pkg::CMD_READ_IDENT:
					q_nxt.rstate[cmd_part] = prs_pkg::RS_IDENT;
				prs_pkg::CMD_READ_QUERY:
					q_nxt.rstate[cmd_part] = prs_pkg::RS_QUERY;
				prs_pkg::CMD_PROGRAM,
				prs_pkg::CMD_ERASE,
				prs_pkg::CMD_LOCK,
				prs_pkg::CMD_PROT_PROGRAM,
				prs_pkg::CMD_OTHER:
					q_nxt.rstate[cmd_part] = prs_pkg::RS_STATUS;
				prs_pkg::CMD_CLEAR_STATUS: ;
			endcase
		end
		// protection programming pins the parameter partition to status
		if (eng_prot_prog) begin
			q_nxt.rstate[prs_pkg::PARAM_PART] = prs_pkg::RS_STATUS;
		end

		// ------------------------------------------------------------
		// access start
		// ------------------------------------------------------------
		// async: first of the two enables to fall starts the access;
		// sync: chip enable or latch must toggle, burst beats do not
		if (!sync_mode) begin
			start = (q_r.prev[prs_pkg::PIN_CE] &&
			         q_r.prev[prs_pkg::PIN_OE]) && !(ce_n && oe_n);
		end else begin
			start = (q_r.prev[prs_pkg::PIN_CE] && !ce_n) ||
			        (q_r.prev[prs_pkg::PIN_ADV] && !adv_n && !ce_n);
		end

		// ------------------------------------------------------------
		// snapshot, violation pulse and burst beats
		// ------------------------------------------------------------
		// the snapshot is taken once per access; a long burst shows
		// stale flags until the host toggles chip enable or the latch
		q_nxt.violation = 1'b0;
		if (start) begin
			q_nxt.lat_part   = part;
			q_nxt.snap       = fl.flags;
			// owner bit only means something while the engine runs
			q_nxt.snap[prs_pkg::FLG_OWNER] = eng_busy &&
			                                 (eng_part != part);
			// one word per access, held for every later beat
			q_nxt.word       = nonarray_data;
			q_nxt.beats      = 5'h00;
			q_nxt.burst_done = 1'b0;
			q_nxt.violation  = bad_param || bad_prot || bad_main;
		end else if (sync_mode && bclk_rise && !ce_n && !q_r.burst_done) begin
			// a stopped burst clock simply holds the count
			q_nxt.beats = cnt;
			// continuous bursts never complete
			if (lim != prs_pkg::BEATS_CONT && cnt == lim) begin
				q_nxt.burst_done = 1'b1;
			end
		end

		// ------------------------------------------------------------
		// data steering
		// ------------------------------------------------------------
		// steer from the partition and snapshot latched in this cycle,
		// so the word is already right on the edge that raises dq_oe
		// array reads are served in every partition the engine is not
		// using, parameter partition included
		s_cur = q_r.rstate[q_nxt.lat_part];
		unique case (s_cur)
			prs_pkg::RS_ARRAY:
				q_nxt.dq_out = array_data;
			prs_pkg::RS_STATUS:
				q_nxt.dq_out = {prs_pkg::STAT_HIGH_BYTE, q_nxt.snap};
			prs_pkg::RS_IDENT,
			prs_pkg::RS_QUERY:
				q_nxt.dq_out = q_nxt.word;
		endcase
		// enable follows the synced pins, so a held enable keeps driving
		q_nxt.dq_oe = !ce_n && !oe_n;
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	// pins reset to their idle high level so that no enable fall is
	// seen on the first edges after reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q_r      <= '0;
			q_r.s1   <= '1;
			q_r.s2   <= '1;
			q_r.prev <= '1;
			q_r.snap <= prs_pkg::FLAGS_RST;
		end else begin
			q_r <= q_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign dq_out           = q_r.dq_out;
	assign dq_oe            = q_r.dq_oe;
	assign burst_done       = q_r.burst_done;
	assign access_violation = q_r.violation;
	assign read_states      = q_r.rstate;

endmodule

`default_nettype wire

//--- bench/prs_read_state_checker.sv
// checker for partition read states and progress flag reads
// assumes: bound to prs_read_state, everything on clk
`default_nettype none

module prs_read_state_checker (
	input wire logic              clk,              // block clock
	input wire logic              rst_n,            // async reset
	input wire logic              sync_mode,        // 1 = burst
	input wire logic              cmd_valid,        // command pulse
	input wire prs_pkg::prs_cmd_t cmd_kind,         // decoded command
	input wire logic [2:0]        cmd_part,         // command partition
	input wire logic              eng_busy,         // engine running
	input wire logic              eng_prot_prog,    // protection program
	input wire logic [15:0]       dq_out,           // data pins out
	input wire logic              dq_oe,            // data pin enable
	input wire logic              burst_done,       // burst delivered
	input wire logic              access_violation, // forbidden access
	input wire logic [15:0]       read_states       // 2 bits/partition
);
	logic [2:0] part_q;
	logic [1:0] kind_q;
	logic [3:0] busy_h;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// command fields one cycle back, to index the new state
	always_ff @(posedge clk) begin
		part_q <= cmd_part;
		kind_q <= cmd_kind[1:0];
	end
	// engine history: snapshot only trusted after a steady engine
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			busy_h <= 4'h0;
		else
			busy_h <= {busy_h[2:0], eng_busy};
	end

	read_cmd_a: assert property (
		cmd_valid && !eng_prot_prog && cmd_kind[3:2] == 2'h0
		|=> read_states[{part_q, 1'b0} +: 2] == kind_q)
		else $error("read command gave wrong state");
	setup_cmd_a: assert property (
		cmd_valid && cmd_kind inside {prs_pkg::CMD_PROGRAM,
		prs_pkg::CMD_ERASE, prs_pkg::CMD_LOCK}
		|=> read_states[{part_q, 1'b0} +: 2] == 2'h1)
		else $error("setup command did not select flags");
	others_kept_a: assert property (
		cmd_valid && !eng_prot_prog |=> ((read_states
		^ $past(read_states)) & ~(16'h3 << {part_q, 1'b0})) == 16'h0)
		else $error("command disturbed another partition");
	prot_status_a: assert property (
		eng_prot_prog [*3] |-> read_states[1:0] == 2'h1)
		else $error("param partition left flag state");
	high_byte_a: assert property (
		dq_oe && read_states == 16'h5555
		&& $past(read_states, 4) == 16'h5555 |-> dq_out[15:8] == 8'h00)
		else $error("flag read high byte not zero");
	idle_flags_a: assert property (
		$rose(dq_oe) && read_states == 16'h5555 && busy_h == 4'h0
		&& $past(read_states, 3) == 16'h5555 |-> dq_out[7] && !dq_out[0])
		else $error("idle flags wrong");
	busy_flag_a: assert property (
		$rose(dq_oe) && read_states == 16'h5555 && busy_h == 4'hf
		&& $past(read_states, 3) == 16'h5555 |-> !dq_out[7])
		else $error("busy engine shown idle");
	viol_pulse_a: assert property (
		access_violation |-> ($past(eng_busy) || $past(eng_prot_prog))
		##1 !access_violation)
		else $error("violation without busy engine or too long");
	burst_mode_a: assert property (
		$rose(burst_done) |-> sync_mode)
		else $error("burst completion outside burst mode");
endmodule

bind prs_read_state prs_read_state_checker prs_read_state_checker_i (
	.clk, .rst_n, .sync_mode, .cmd_valid, .cmd_kind, .cmd_part, .eng_busy,
	.eng_prot_prog, .dq_out, .dq_oe, .burst_done, .access_violation,
	.read_states);

`default_nettype wire

//--- bench/prs_host_model.sv
// host controller model driving the flash read pins
// assumes: caller waits 3 edges after reset before the first access
`default_nettype none

module prs_host_model (
	input  wire logic  clk,             // block clock
	input  wire logic  dq_oe,           // data pins driven
	output logic       chip_en_n,       // chip enable
	output logic       out_en_n,        // output enable
	output logic       address_latch_n, // address latch
	output logic       burst_clk,       // burst clock
	output logic [2:0] part_addr        // read partition
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		chip_en_n = 1'b1;
		out_en_n = 1'b1;
		address_latch_n = 1'b1;
		burst_clk = 1'b0;
		part_addr = 3'h0;
	end

	task automatic tick();
		@(posedge clk);
		#1;
	endtask

	// beats 0: async single word, else a burst of that many clocks
	task automatic access(input logic [2:0] p, input int beats,
		output bit ok);
		int n;
		ok = 1'b0;
		tick();
		part_addr = p;
		chip_en_n = 1'b0; // fresh enable fall per access
		address_latch_n = (beats == 0);
		out_en_n = 1'b0;
		for (n = 0; n < 20 && !ok; n++) begin
			tick();
			ok = dq_oe;
		end
		address_latch_n = 1'b1;
		for (n = 0; n < 2 * beats; n++) begin
			tick();
			burst_clk = ~burst_clk;
		end
		repeat (6) tick();
		chip_en_n = 1'b1;
		out_en_n = 1'b1;
		// deselected: the address must not look stable
		part_addr = ~p;
		repeat (4) tick();
	endtask
endmodule

`default_nettype wire

//--- bench/prs_read_state_tb.sv
// self-checking bench for the partition read-state block
// assumes: design and checker compiled first, host model drives the pins
`default_nettype none

module prs_read_state_tb;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk, rst_n, chip_en_n, out_en_n, address_latch_n, burst_clk;
	logic sync_mode, cmd_valid, eng_busy, eng_prot_prog, seq_err;
	logic eng_erase_hold, eng_prog_hold, dq_oe, burst_done;
	logic access_violation, oe_q, bd_q;
	logic [2:0] part_addr, burst_len, cmd_part, eng_part;
	logic [3:0] sets;
	logic [7:0] fl;
	logic [15:0] array_data, nonarray_data, dq_out, read_states;
	logic [16:0] got, want;
	logic [16:0] notes[$];
	prs_pkg::prs_cmd_t cmd_kind;
	int bad_count, checked, seed, i;
	bit ok;

	prs_read_state prs_read_state_i (.clk, .rst_n, .chip_en_n, .out_en_n,
		.address_latch_n, .burst_clk, .part_addr, .sync_mode, .burst_len,
		.cmd_valid, .cmd_kind, .cmd_part, .eng_busy, .eng_part,
		.eng_prot_prog, .eng_erase_hold, .eng_prog_hold,
		.set_erase_fail(sets[3]), .set_prog_fail(sets[2]),
		.set_supply_low(sets[1]), .set_locked(sets[0]), .seq_err,
		.array_data, .nonarray_data, .dq_out, .dq_oe, .burst_done,
		.access_violation, .read_states);
	prs_host_model prs_host_model_i (.clk, .dq_oe, .chip_en_n, .out_en_n,
		.address_latch_n, .burst_clk, .part_addr);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic tick();
		@(posedge clk);
		#1;
	endtask

	task automatic conclude();
		if (notes.size() != 0)
			bad_count++;
		if (bad_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic cmd(input prs_pkg::prs_cmd_t k, input logic [2:0] p);
		tick();
		cmd_valid = 1'b1;
		cmd_kind = k;
		cmd_part = p;
		tick();
		cmd_valid = 1'b0;
	endtask

	task automatic pulse(input logic [4:0] s);
		tick();
		{seq_err, sets} = s;
		tick();
		{seq_err, sets} = 5'h00;
	endtask

	// k: 0 array word, 1 non-array word, 2 flag byte; v: violation
	task automatic rd(input logic [2:0] p, input logic [1:0] k,
		input logic v = 1'b0, input int beats = 0);
		array_data = 16'($random(seed));
		nonarray_data = 16'($random(seed));
		notes.push_back({v, (k == 2'h0) ? array_data :
			(k == 2'h1) ? nonarray_data : {8'h00, fl}});
		if (beats != 0)
			notes.push_back({1'b0, 8'h00, fl});
		prs_host_model_i.access(p, beats, ok);
		if (!ok) begin
			bad_count++;
			conclude();
		end
	endtask

	// results: enable rise and burst completion, oldest note first
	always @(negedge clk) begin
		if (rst_n && ((dq_oe && !oe_q) || (burst_done && !bd_q))) begin
			checked++;
			got = {access_violation, dq_out};
			want = (notes.size() == 0) ? 17'h00000 : notes.pop_front();
			if (got !== want) begin
				bad_count++;
				$display("[ERR] %0t got %h want %h", $time, got, want);
			end
		end
		oe_q = dq_oe;
		bd_q = burst_done;
	end

	initial begin
		{rst_n, sync_mode, cmd_valid, eng_busy, eng_prot_prog} = 5'h00;
		{seq_err, sets, eng_erase_hold, eng_prog_hold} = 7'h00;
		{oe_q, bd_q, cmd_part, eng_part, burst_len} = 11'h001;
		{array_data, nonarray_data} = 32'h0;
		cmd_kind = prs_pkg::CMD_READ_ARRAY;
		seed = 81;
		fl = 8'h80;
		repeat (6) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (3) tick();
		rd(3'h3, 2'h0);
		cmd(prs_pkg::CMD_READ_QUERY, 3'h3);
		cmd(prs_pkg::CMD_READ_IDENT, 3'h5);
		rd(3'h3, 2'h1);
		rd(3'h5, 2'h1);
		rd(3'h2, 2'h0);
		eng_part = 3'h5;
		eng_busy = 1'b1;
		rd(3'h3, 2'h1);
		rd(3'h0, 2'h0);
		cmd(prs_pkg::CMD_READ_QUERY, 3'h0);
		// deliberate forbidden mix in the param partition
		rd(3'h0, 2'h1, 1'b1);
		cmd(prs_pkg::CMD_READ_ARRAY, 3'h0);
		eng_part = 3'h0;
		rd(3'h3, 2'h1, 1'b1);
		rd(3'h4, 2'h0);
		eng_prot_prog = 1'b1;
		rd(3'h4, 2'h0);
		{eng_prot_prog, eng_busy} = 2'h0;
		repeat (4) tick();
		for (i = 0; i < 8; i++)
			cmd(prs_pkg::CMD_READ_STATUS, 3'(i));
		rd(3'h4, 2'h2);
		eng_part = 3'h2;
		eng_busy = 1'b1;
		fl = 8'h00;
		rd(3'h2, 2'h2);
		fl = 8'h01;
		rd(3'h6, 2'h2);
		{eng_busy, eng_erase_hold, eng_prog_hold} = 3'h3;
		fl = 8'hc4;
		rd(3'h1, 2'h2);
		{eng_erase_hold, eng_prog_hold} = 2'h0;
		fl = 8'h80;
		for (i = 0; i < 4; i++) begin
			pulse(5'(1 << i));
			fl[(i == 0) ? 1 : i + 2] = 1'b1;
			rd(3'h1, 2'h2);
		end
		cmd(prs_pkg::CMD_CLEAR_STATUS, 3'h1);
		fl = 8'h80;
		rd(3'h1, 2'h2);
		pulse(5'h10);
		fl = 8'hb0;
		rd(3'h7, 2'h2);
		cmd(prs_pkg::CMD_CLEAR_STATUS, 3'h7);
		fl = 8'h80;
		sync_mode = 1'b1;
		for (i = 1; i < 4; i++) begin
			burst_len = 3'(i);
			fork
				rd(3'h4, 2'h2, 1'b0, 4 << (i - 1));
				begin
					repeat (8) tick();
					pulse(5'h01);
				end
			join
			fl[1] = 1'b1;
		end
		sync_mode = 1'b0;
		rd(3'h4, 2'h2);
		for (i = 0; i < 3; i++) begin
			cmd(prs_pkg::CMD_READ_ARRAY, 3'h3);
			cmd(prs_pkg::prs_cmd_t'(4 + i), 3'h3);
			rd(3'h3, 2'h2);
		end
		conclude();
	end
endmodule

`default_nettype wire
